// File: verilog/dsr_pkg.sv
// Constants and a helper function for the serial register access block.
// How it works
// RQ1 - Command byte selects register for writes, reads
// RQ2 - Two data bytes, upper first, form word
// RQ3 - Commit word at falling edge ending final acknowledge
// RQ4 - Output code is left aligned by resolution
// RQ5 - No-operation writes change nothing at all
// RQ6 - Identification read-only: resolution code, power-on scale
// RQ7 - Unassigned commands ignore writes, read as zero
// RQ8 - Four bytes, each acknowledged, thirty-six clocks
// RQ9 - Sync enable holds code until load strobe
package dsr_pkg;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h01;
  localparam logic [7:0] CMD_SYNC = 8'h02;
  localparam logic [7:0] CMD_POWER = 8'h03;
  localparam logic [7:0] CMD_GAIN = 8'h04;
  localparam logic [7:0] CMD_TRIG = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h07;
  localparam logic [7:0] CMD_CODE = 8'h08;

  localparam logic [3:0] TARGET_ADDR_HI = 4'h9;
  localparam logic [3:0] BIT_CNT_ACK = 4'h8;
  localparam logic [3:0] BIT_CNT_END = 4'h9;

  localparam int SYNC_EN_BIT = 0;
  localparam int REF_PWDN_BIT = 8;
  localparam int DAC_PWDN_BIT = 0;
  localparam int REF_DIV_BIT = 8;
  localparam int BUF_GAIN_BIT = 0;
  localparam int LOAD_STROBE_BIT = 4;
  localparam int ALARM_BIT = 0;
  localparam int SCALE_BIT = 7;

  localparam logic SYNC_EN_RST = 1'b0;
  localparam logic REF_PWDN_RST = 1'b0;
  localparam logic DAC_PWDN_RST = 1'b0;
  localparam logic REF_DIV_RST = 1'b0;
  localparam logic BUF_GAIN_RST = 1'b1;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] SOFT_RESET_CODE = 4'ha;

  // Keeps the upper code bits of a left-aligned word for the given resolution.
  function automatic logic [15:0] dsr_align(input logic [15:0] data, input int bits);
    logic [15:0] mask;
    mask = 16'hffff << (16 - bits);
    return data & mask;
  endfunction

endpackage

// File: verilog/dsr_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs.
module dsr_sync2 import dsr_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic CLK_I,                // System clock.
  input wire logic NRST_I,               // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_i,  // Asynchronous inputs.
  output logic [WIDTH-1:0] sync_o        // Synchronised outputs.
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule // dsr_sync2

// File: verilog/dsr_output_stage.sv
// Output code register and the code that drives the converter.
module dsr_output_stage import dsr_pkg::*; #(
  parameter int RES_BITS = 16,
  parameter logic POWER_ON_MID = 1'b0
) (
  input wire logic CLK_I,           // System clock.
  input wire logic NRST_I,          // Asynchronous reset, active low.
  input wire logic wr_i,            // Write pulse for the code register.
  input wire logic [15:0] data_i,   // Word written.
  input wire logic load_i,          // Load strobe pulse.
  input wire logic sync_en_i,       // Hold writes until the load strobe.
  input wire logic soft_rst_i,      // Return to the power-on code.
  output logic [15:0] code_o,       // Stored code, left aligned.
  output logic [15:0] active_o      // Code presented to the converter.
);

  localparam logic [15:0] POR_CODE = POWER_ON_MID ? CODE_MID : CODE_ZERO;

  logic [15:0] code_r;
  logic [15:0] code_nxt;
  logic [15:0] active_r;
  logic [15:0] active_nxt;

  always_comb begin
    code_nxt = code_r;
    active_nxt = active_r;
    if (soft_rst_i) begin
      code_nxt = POR_CODE;
      active_nxt = POR_CODE;
    end else begin
      if (wr_i) begin
        code_nxt = dsr_align(data_i, RES_BITS); // RQ4
        if (!sync_en_i) begin
          active_nxt = dsr_align(data_i, RES_BITS); // RQ9
        end
      end
      if (load_i) begin
        active_nxt = code_r; // RQ9
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      code_r <= POR_CODE;
      active_r <= POR_CODE;
    end else begin
      code_r <= code_nxt;
      active_r <= active_nxt;
    end
  end

  assign code_o = code_r;
  assign active_o = active_r;

endmodule // dsr_output_stage

// File: verilog/dsr_top.sv
// Two-wire serial target with the converter's command-selected register bank.
module dsr_top import dsr_pkg::*; #(
  parameter int RES_BITS = 16,
  parameter logic POWER_ON_MID = 1'b0,
  parameter logic [2:0] ID_RES_CODE = 3'h3,   // Arbitrary value.
  parameter logic [3:0] ID_MID_BITS = 4'h6,   // Arbitrary value.
  parameter logic [6:0] ID_LOW_BITS = 7'h2c   // Arbitrary value.
) (
  input wire logic CLK_I,            // System clock, 40 MHz.
  input wire logic NRST_I,           // Asynchronous reset, active low.
  input wire logic SCL_I,            // Serial clock pin.
  input wire logic SDA_I,            // Serial data pin level.
  output logic SDA_O,                // Serial data drive value.
  output logic SDA_OE_O,             // Serial data drive enable.
  input wire logic [2:0] ADDR_SEL_I, // Low three target address bits.
  input wire logic REF_ALARM_I,      // Reference alarm condition.
  output logic [15:0] DAC_CODE_O,    // Code presented to the converter.
  output logic SYNC_EN_O,            // Synchronous update mode.
  output logic DAC_PWDN_O,           // Converter power-down.
  output logic REF_PWDN_O,           // Internal reference disable.
  output logic REF_DIV_O,            // Reference divide by two.
  output logic BUF_GAIN_O            // Output buffer gain select.
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_HI,
    ST_LO,
    ST_TX_HI,
    ST_TX_LO
  } dsr_link_state_t;

  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_sel_s;
  logic alarm_s;

  dsr_sync2 #(.WIDTH(6)) u_sync (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .async_i({REF_ALARM_I, ADDR_SEL_I, SDA_I, SCL_I}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign addr_sel_s = pins_s[4:2];
  assign alarm_s = pins_s[5];

  dsr_link_state_t state_r;
  dsr_link_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] rx_sr_r;
  logic [7:0] rx_sr_nxt;
  logic [15:0] tx_sr_r;
  logic [15:0] tx_sr_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic nack_r;
  logic nack_nxt;
  logic scl_d_r;
  logic scl_d_nxt;
  logic sda_d_r;
  logic sda_d_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic commit;
  logic [15:0] rd_word;
  logic [15:0] code_q;

  logic sync_en_r;
  logic sync_en_nxt;
  logic ref_pwdn_r;
  logic ref_pwdn_nxt;
  logic dac_pwdn_r;
  logic dac_pwdn_nxt;
  logic ref_div_r;
  logic ref_div_nxt;
  logic buf_gain_r;
  logic buf_gain_nxt;
  logic code_wr;
  logic load_pulse;
  logic soft_rst;
  logic [15:0] wr_word;

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign wr_word = {hi_r, rx_sr_r}; // RQ2

  // Read data for the register chosen by the last command byte.
  always_comb begin
    case (cmd_r) // RQ1
      CMD_IDENT: rd_word = {1'b0, ID_RES_CODE, ID_MID_BITS, POWER_ON_MID, ID_LOW_BITS}; // RQ6
      CMD_SYNC: rd_word = {15'h0000, sync_en_r};
      CMD_POWER: rd_word = {7'h00, ref_pwdn_r, 7'h00, dac_pwdn_r};
      CMD_GAIN: rd_word = {7'h00, ref_div_r, 7'h00, buf_gain_r};
      CMD_STATUS: rd_word = {15'h0000, alarm_s};
      CMD_CODE: rd_word = code_q;
      default: rd_word = WORD_ZERO; // RQ7
    endcase
  end

  // Serial link: bits are sampled on the clock rise and driven after its fall.
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_sr_nxt = rx_sr_r;
    tx_sr_nxt = tx_sr_r;
    cmd_nxt = cmd_r;
    hi_nxt = hi_r;
    sda_oe_nxt = sda_oe_r;
    nack_nxt = nack_r;
    scl_d_nxt = scl_s;
    sda_d_nxt = sda_s;
    commit = 1'b0;
    if (stop_det) begin
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise) begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
        if (bit_cnt_r < BIT_CNT_ACK) begin
          rx_sr_nxt = {rx_sr_r[6:0], sda_s};
        end else begin
          nack_nxt = sda_s;
        end
      end else if (scl_fall) begin
        if (bit_cnt_r == BIT_CNT_ACK) begin
          case (state_r) // RQ8
            ST_ADDR: begin
              if (rx_sr_r[7:1] == {TARGET_ADDR_HI, addr_sel_s}) begin
                sda_oe_nxt = 1'b1;
              end else begin
                state_nxt = ST_IDLE;
              end
            end
            ST_CMD, ST_HI, ST_LO: sda_oe_nxt = 1'b1;
            default: sda_oe_nxt = 1'b0;
          endcase
        end else if (bit_cnt_r == BIT_CNT_END) begin
          bit_cnt_nxt = 4'h0;
          sda_oe_nxt = 1'b0;
          case (state_r)
            ST_ADDR: begin
              if (rx_sr_r[0]) begin
                state_nxt = ST_TX_HI;
                sda_oe_nxt = ~rd_word[15];
                tx_sr_nxt = {rd_word[14:0], 1'b0};
              end else begin
                state_nxt = ST_CMD;
              end
            end
            ST_CMD: begin
              cmd_nxt = rx_sr_r; // RQ1
              state_nxt = ST_HI;
            end
            ST_HI: begin
              hi_nxt = rx_sr_r; // RQ2
              state_nxt = ST_LO;
            end
            ST_LO: begin
              commit = 1'b1; // RQ3
              state_nxt = ST_IDLE;
            end
            ST_TX_HI: begin
              if (nack_r) begin
                state_nxt = ST_IDLE;
              end else begin
                state_nxt = ST_TX_LO;
                sda_oe_nxt = ~tx_sr_r[15];
                tx_sr_nxt = {tx_sr_r[14:0], 1'b0};
              end
            end
            default: state_nxt = ST_IDLE;
          endcase
        end else if (state_r == ST_TX_HI || state_r == ST_TX_LO) begin
          sda_oe_nxt = ~tx_sr_r[15];
          tx_sr_nxt = {tx_sr_r[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_sr_r <= 8'h00;
      tx_sr_r <= 16'h0000;
      cmd_r <= CMD_NOP;
      hi_r <= 8'h00;
      sda_oe_r <= 1'b0;
      nack_r <= 1'b0;
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_sr_r <= rx_sr_nxt;
      tx_sr_r <= tx_sr_nxt;
      cmd_r <= cmd_nxt;
      hi_r <= hi_nxt;
      sda_oe_r <= sda_oe_nxt;
      nack_r <= nack_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  // Register bank updates, taken only on the committing edge.
  always_comb begin
    sync_en_nxt = sync_en_r;
    ref_pwdn_nxt = ref_pwdn_r;
    dac_pwdn_nxt = dac_pwdn_r;
    ref_div_nxt = ref_div_r;
    buf_gain_nxt = buf_gain_r;
    code_wr = 1'b0;
    load_pulse = 1'b0;
    soft_rst = 1'b0;
    if (commit) begin
      case (cmd_r) // RQ1
        CMD_SYNC: sync_en_nxt = wr_word[SYNC_EN_BIT];
        CMD_POWER: begin
          ref_pwdn_nxt = wr_word[REF_PWDN_BIT];
          dac_pwdn_nxt = wr_word[DAC_PWDN_BIT];
        end
        CMD_GAIN: begin
          ref_div_nxt = wr_word[REF_DIV_BIT];
          buf_gain_nxt = wr_word[BUF_GAIN_BIT];
        end
        CMD_TRIG: begin
          load_pulse = wr_word[LOAD_STROBE_BIT]; // RQ9
          soft_rst = (wr_word[3:0] == SOFT_RESET_CODE);
        end
        CMD_CODE: code_wr = 1'b1;
        default: code_wr = 1'b0; // RQ5 RQ7
      endcase
    end
    if (soft_rst) begin
      sync_en_nxt = SYNC_EN_RST;
      ref_pwdn_nxt = REF_PWDN_RST;
      dac_pwdn_nxt = DAC_PWDN_RST;
      ref_div_nxt = REF_DIV_RST;
      buf_gain_nxt = BUF_GAIN_RST;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync_en_r <= SYNC_EN_RST;
      ref_pwdn_r <= REF_PWDN_RST;
      dac_pwdn_r <= DAC_PWDN_RST;
      ref_div_r <= REF_DIV_RST;
      buf_gain_r <= BUF_GAIN_RST;
    end else begin
      sync_en_r <= sync_en_nxt;
      ref_pwdn_r <= ref_pwdn_nxt;
      dac_pwdn_r <= dac_pwdn_nxt;
      ref_div_r <= ref_div_nxt;
      buf_gain_r <= buf_gain_nxt;
    end
  end

  dsr_output_stage #(.RES_BITS(RES_BITS), .POWER_ON_MID(POWER_ON_MID)) u_out (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .wr_i(code_wr),
    .data_i(wr_word),
    .load_i(load_pulse),
    .sync_en_i(sync_en_r),
    .soft_rst_i(soft_rst),
    .code_o(code_q),
    .active_o(DAC_CODE_O)
  );

  // Open-drain data pin: only ever pulls low.
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;
  assign SYNC_EN_O = sync_en_r;
  assign DAC_PWDN_O = dac_pwdn_r;
  assign REF_PWDN_O = ref_pwdn_r;
  assign REF_DIV_O = ref_div_r;
  assign BUF_GAIN_O = buf_gain_r;

endmodule // dsr_top

// File: test/dsr_ctrl_model.sv
// Serial bus controller model: drives the clock and an open-drain data line.
module dsr_ctrl_model (
  input wire logic clk_i, // Bench clock.
  input wire logic sda_i, // Resolved data wire.
  output logic scl_o,     // Serial clock, high while idle.
  output logic sda_o      // Data drive, 1 releases the pulled-up wire.
);
  timeunit 1ns;
  timeprecision 100ps;
  int lag = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // Data changes only while the clock is low; the wire is read mid-high.
  task automatic bit_io(input logic b, output logic q);
    tick(lag);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    q = sda_i;
    tick(2);
    scl_o <= 1'b0;
    tick(2);
  endtask
  // Eight bits, most significant first, then the acknowledge clock.
  task automatic xfer(input logic [7:0] d, input logic ack_o, output logic [7:0] q,
                      output logic ack_i);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_o, ack_i);
  endtask
endmodule // dsr_ctrl_model

// File: test/dsr_top_properties.sv
// Concurrent checks on the serial register block's top-level ports.
module dsr_top_properties #(
  parameter int RES_BITS = 16
) (
  input wire logic CLK_I,             // System clock.
  input wire logic NRST_I,            // Reset, active low.
  input wire logic SCL_I,             // Serial clock pin.
  input wire logic SDA_O,             // Data drive value.
  input wire logic SDA_OE_O,          // Data drive enable.
  input wire logic [15:0] DAC_CODE_O, // Converter code.
  input wire logic SYNC_EN_O,         // Sync mode.
  input wire logic DAC_PWDN_O,        // Converter power-down.
  input wire logic REF_PWDN_O,        // Reference disable.
  input wire logic REF_DIV_O,         // Reference divide.
  input wire logic BUF_GAIN_O         // Buffer gain.
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MASK = 16'hffff << (16 - RES_BITS);
  logic scl_r, scl_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [4:0] pins;
  assign pins = {SYNC_EN_O, REF_PWDN_O, DAC_PWDN_O, REF_DIV_O, BUF_GAIN_O};
  // Counts clock cycles since the serial clock last fell, saturating.
  always_comb begin
    scl_nxt = SCL_I;
    cnt_nxt = cnt_r;
    if (scl_r && !SCL_I) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r != 4'hf) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      scl_r <= 1'b1;
      cnt_r <= 4'hf;
    end else begin
      scl_r <= scl_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_ack_pulls_low: assert property (SDA_OE_O |-> !SDA_O)
    else $error("data line driven high");
  a_drive_starts_late: assert property ($rose(SDA_OE_O) |-> cnt_r inside {[1:6]})
    else $error("drive began away from a clock fall");
  a_drive_ends_late: assert property ($fell(SDA_OE_O) |-> cnt_r inside {[1:6]})
    else $error("drive ended away from a clock fall");
  a_drive_holds_high: assert property (
    SCL_I && $past(SCL_I) && $past(SCL_I, 2) |-> $stable(SDA_OE_O))
    else $error("drive changed while clock high");
  a_pins_after_fall: assert property ($changed(pins) |-> cnt_r inside {[1:7]})
    else $error("control pins changed away from an ack fall");
  a_code_after_fall: assert property ($changed(DAC_CODE_O) |-> cnt_r inside {[1:8]})
    else $error("code changed away from an ack fall");
  a_code_aligned: assert property ((DAC_CODE_O & ~MASK) == 16'h0000)
    else $error("code not left aligned");
  a_reset_values: assert property (
    $rose(NRST_I) |-> pins == 5'b00001 && DAC_CODE_O == 16'h0000)
    else $error("wrong values out of reset");
  c_ack: cover property ($rose(SDA_OE_O));
  c_code: cover property ($changed(DAC_CODE_O));
  c_sync: cover property ($rose(SYNC_EN_O));
endmodule // dsr_top_properties

// File: test/dsr_top_tb.sv
// Testbench for the serial register block: frames, readback and output pins.
module dsr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RES = 12;
  localparam logic [15:0] MASK = 16'hffff << (16 - RES);
  localparam logic [6:0] TGT = {4'h9, 3'h2};
  localparam logic [2:0] ID_RES = 3'h3;  // Arbitrary value.
  localparam logic [3:0] ID_MID = 4'h5;  // Arbitrary value.
  localparam logic [6:0] ID_LOW = 7'h1b; // Arbitrary value.
  localparam logic [15:0] IDENT = {1'b0, ID_RES, ID_MID, 1'b0, ID_LOW};
  logic clk, nrst, scl, sda_m, sda_w, sda_o, sda_oe, alarm;
  logic sync_en, dac_pd, ref_pd, ref_div, buf_gain;
  logic [2:0] addr_sel;
  logic [15:0] code, r;
  logic [4:0] pins;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  assign sda_w = sda_m & !(sda_oe & !sda_o);
  assign pins = {sync_en, ref_pd, dac_pd, ref_div, buf_gain};
  dsr_top #(.RES_BITS(RES), .POWER_ON_MID(1'b0), .ID_RES_CODE(ID_RES), .ID_MID_BITS(ID_MID),
    .ID_LOW_BITS(ID_LOW)) dsr_top_i (
    .CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .ADDR_SEL_I(addr_sel), .REF_ALARM_I(alarm), .DAC_CODE_O(code),
    .SYNC_EN_O(sync_en), .DAC_PWDN_O(dac_pd), .REF_PWDN_O(ref_pd), .REF_DIV_O(ref_div),
    .BUF_GAIN_O(buf_gain)
  );
  dsr_ctrl_model dsr_ctrl_model_i (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  always #12.5 clk = ~clk;
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Write frame: address, command, upper byte, lower byte; counts the acks.
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, output int acks);
    logic [7:0] b [4];
    logic [7:0] q;
    logic a;
    b = '{{TGT, 1'b0}, cmd, d[15:8], d[7:0]};
    acks = 0;
    dsr_ctrl_model_i.start();
    for (int i = 0; i < 4; i++) begin
      dsr_ctrl_model_i.xfer(b[i], 1'b1, q, a);
      acks += int'(!a);
    end
    dsr_ctrl_model_i.stop();
  endtask
  // Write frame cut by a stop before the lower byte: nothing may be applied.
  task automatic wr_cut(input logic [7:0] cmd, input logic [7:0] hi);
    logic [7:0] q;
    logic a;
    dsr_ctrl_model_i.start();
    dsr_ctrl_model_i.xfer({TGT, 1'b0}, 1'b1, q, a);
    dsr_ctrl_model_i.xfer(cmd, 1'b1, q, a);
    dsr_ctrl_model_i.xfer(hi, 1'b1, q, a);
    dsr_ctrl_model_i.stop();
  endtask
  // Read frame: command written, repeated start, two bytes read, last one refused.
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic [7:0] q;
    logic a;
    dsr_ctrl_model_i.start();
    dsr_ctrl_model_i.xfer({TGT, 1'b0}, 1'b1, q, a);
    dsr_ctrl_model_i.xfer(cmd, 1'b1, q, a);
    dsr_ctrl_model_i.start();
    dsr_ctrl_model_i.xfer({TGT, 1'b1}, 1'b1, q, a);
    dsr_ctrl_model_i.xfer(8'hff, 1'b0, d[15:8], a);
    dsr_ctrl_model_i.xfer(8'hff, 1'b1, d[7:0], a);
    dsr_ctrl_model_i.stop();
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    alarm = 1'b0;
    addr_sel = 3'h2;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    chk16({11'h0, pins}, 16'h0001);
    chk16(code, 16'h0000);
    rd(8'h01, r);
    chk16(r, IDENT);
    wr(8'h01, 16'h0000, n);
    rd(8'h01, r);
    chk16(r, IDENT);
    wr(8'h03, 16'hffff, n);
    chk16(16'(n), 16'h0004);
    chk16({11'h0, pins}, 16'h000d);
    rd(8'h03, r);
    chk16(r, 16'h0101);
    wr(8'h04, 16'h0100, n);
    rd(8'h04, r);
    chk16(r, 16'h0100);
    for (int i = 0; i < 2; i++) begin
      wr(i == 0 ? 8'h00 : 8'h06, 16'hffff, n);
      chk16({11'h0, pins}, 16'h000e);
    end
    rd(8'h06, r);
    chk16(r, 16'h0000);
    rd(8'h03, r);
    chk16(r, 16'h0101);
    alarm <= 1'b1;
    rd(8'h07, r);
    chk16(r, 16'h0001);
    dsr_ctrl_model_i.lag = 6;
    wr(8'h08, 16'ha5c3, n);
    dsr_ctrl_model_i.lag = 0;
    chk16(code, 16'ha5c3 & MASK);
    wr_cut(8'h08, 8'h12);
    chk16(code, 16'ha5c3 & MASK);
    rd(8'h08, r);
    chk16(r, 16'ha5c3 & MASK);
    addr_sel <= 3'h5;
    wr(8'h08, 16'h1110, n);
    addr_sel <= 3'h2;
    chk16(16'(n), 16'h0000);
    chk16(code, 16'ha5c3 & MASK);
    wr(8'h02, 16'h0001, n);
    wr(8'h08, 16'h1230, n);
    chk16(code, 16'ha5c3 & MASK);
    rd(8'h08, r);
    chk16(r, 16'h1230);
    wr(8'h05, 16'h0010, n);
    chk16(code, 16'h1230);
    wr(8'h05, 16'h000a, n);
    chk16({11'h0, pins}, 16'h0001);
    chk16(code, 16'h0000);
    close_out();
  end
endmodule // dsr_top_tb
bind dsr_top dsr_top_properties #(.RES_BITS(RES_BITS)) dsr_top_properties_i (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .DAC_CODE_O(DAC_CODE_O), .SYNC_EN_O(SYNC_EN_O), .DAC_PWDN_O(DAC_PWDN_O),
  .REF_PWDN_O(REF_PWDN_O), .REF_DIV_O(REF_DIV_O), .BUF_GAIN_O(BUF_GAIN_O)
);
